// file: ihd_pkg.sv
// Shared constants and carrier types for the ISA host data port block
package ihd_pkg;
   // APB byte offsets
   localparam logic [7:0] OFS_RSTART = 8'h00;
   localparam logic [7:0] OFS_RCOUNT = 8'h04;
   localparam logic [7:0] OFS_CONFIG = 8'h08;
   localparam logic [7:0] OFS_SHCTL1 = 8'h0C;
   localparam logic [7:0] OFS_SHCTL2 = 8'h10;
   localparam logic [7:0] OFS_CMD    = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_RADDR  = 8'h1C;
   // Field positions
   localparam int CFG_WTS_BIT   = 0;
   localparam int CFG_LATE_BIT  = 1;
   localparam int CFG_SHM_BIT   = 2;
   localparam int SH1_EN_BIT    = 6;
   localparam int SH1_A19_BIT   = 7;
   localparam int CMD_RD_BIT    = 0;
   localparam int CMD_WR_BIT    = 1;
   localparam int CMD_ABORT_BIT = 2;
   // Reset values
   localparam logic [15:0] RST_WORD16 = 16'h0000;
   localparam logic [7:0]  RST_BYTE   = 8'h00;
   // ISA I/O decode: 32-byte block, data port at offset 10h
   localparam logic [9:0] IO_BASE     = 10'h300;
   localparam logic [4:0] IO_PORT_OFS = 5'h10;
   // Window sizes
   localparam logic [1:0] WIN_8K  = 2'h0;
   localparam logic [1:0] WIN_16K = 2'h1;
   localparam logic [1:0] WIN_32K = 2'h2;
   localparam logic [1:0] WIN_64K = 2'h3;

   typedef struct packed {
      logic [3:0]  la_hi;
      logic [19:0] sa;
      logic        aen;
      logic        sbhe_n;
      logic        ior_n;
      logic        iow_n;
      logic        mrd_n;
      logic        mwr_n;
      logic [15:0] sd;
   } ihd_isa_in_t;

   typedef struct packed {
      logic        en;
      logic        we;
      logic [1:0]  be;
      logic [15:0] addr;
      logic [15:0] wdata;
   } ihd_ram_req_t;

   typedef enum logic [4:0] {
      RM_IDLE = 5'h01,
      RM_ARB  = 5'h02,
      RM_ACC  = 5'h04,
      RM_CAPT = 5'h08,
      RM_HOST = 5'h10
   } ihd_rm_state_t;

   typedef enum logic [2:0] {
      SH_IDLE = 3'h1,
      SH_ACC  = 3'h2,
      SH_HOLD = 3'h4
   } ihd_sh_state_t;
endpackage

// file: ihd_host_port.sv
// ISA host data port, shared-window decode, remote DMA and RAM arbitration
//
// Contract
// R1: Remote read fetches a word into the latch, then advances address, reduces count.
// R2: Host port read with empty latch is stretched by wait until data present.
// R3: Host port read strobe acknowledges the remote DMA, which fetches the next word.
// R4: Remote transfers repeat until byte count is zero, then remote DMA ends.
// R5: Remote DMA arbitrates per word, releases RAM after each, waits for local DMA.
// R6: Remote write moves latched host data to RAM; latch writes blocked while full.
// R7: Shared access waits for running local DMA; earlier shared access finishes first.
// R8: Shared decode enabled only while the shared window enable bit is set.
// R9: Width pin low: base from first control register, A19 must be one.
// R10: Compare A13-18 for 8k; skip A13 16k, A13-14 32k, A13-15 64k.
// R11: Width pin high: base from both registers, A19 programmable, same partial decode.
// R12: Shared access completes at once when idle, waits during local DMA, uses RAM; code pulls CHRDY low until SH_HOLD even when idle.
// R13: All host register accesses are byte wide.
// R14: Respond to I/O only on own SA0-9 decode with strobe; ignore when AEN high.
// R15: Pull CHRDY inactive while not ready; leave it untouched when ready.
// R16: Register and 8-bit port reads drive data on SD0-7.
// R17: Register and 8-bit port writes take data from SD0-7.
// R18: 16-bit port decode asserts IO16; late select waits for the strobe.
// R19: Host drives SBHE low with even address for 16-bit port transfers.
// R20: 16-bit mode port reads drive SD0-15, writes take SD0-15.
// R21: Port width follows word transfer select bit and width-select pin.
// R22: In 16-bit mode each port access reduces the byte count by two.
`timescale 1ns/1ns
module ihd_host_port (
   input  wire logic                clk,
   input  wire logic                rst,
   // APB slave
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic                     pready,
   output logic [31:0]              prdata,
   output logic                     pslverr,
   // ISA side
   input  wire ihd_pkg::ihd_isa_in_t isa_i,
   input  wire logic                bus_width_select_pin,
   output logic [15:0]              sd_o,
   output logic [1:0]               sd_oe_n,
   output logic                     chrdy_o,
   output logic                     chrdy_oe_n,
   output logic                     io16_o,
   output logic                     io16_oe_n,
   // Buffer RAM and local DMA
   output ihd_pkg::ihd_ram_req_t    ram_o,
   input  wire logic [15:0]         ram_rdata,
   input  wire logic                local_req,
   output logic                     local_gnt
);
   // Register state
   logic [15:0] rstart_r, rcount_r, raddr_r;
   logic [2:0]  config_r;
   logic [7:0]  shctl1_r, shctl2_r;
   logic        rm_dir_wr_r;
   logic [15:0] latch_r;
   logic        latch_full_r;
   logic        local_gnt_r;
   ihd_pkg::ihd_rm_state_t rm_state_r, rm_nxt;
   ihd_pkg::ihd_sh_state_t sh_state_r, sh_nxt;
   logic [15:0] sh_data_r;
   logic        ior_prev_r, iow_prev_r;
   logic [15:0] wdat_r;
   logic [4:0]  ioofs_r;
   logic        wide_acc_r;

   // Word view of register state for APB and ISA reads
   function automatic logic [15:0] reg_word(input logic [2:0] idx, input logic [15:0] st);
      logic [15:0] w;
      w = 16'h0000;
      case (idx)
         3'h0:    w = rstart_r;
         3'h1:    w = rcount_r;
         3'h2:    w = {13'h0000, config_r};
         3'h3:    w = {8'h00, shctl1_r};
         3'h4:    w = {8'h00, shctl2_r};
         3'h6:    w = st;
         3'h7:    w = raddr_r;
         default: w = 16'h0000;
      endcase
      return w;
   endfunction

   // Window compare with size-dependent don't-care bits
   function automatic logic win_match(input logic [19:0] a, input logic [3:0] la, input logic wid);
      logic [5:0] m;
      logic       ok;
      m = 6'h3F;
      case (shctl2_r[5:4])
         ihd_pkg::WIN_8K:  m = 6'h3F;
         ihd_pkg::WIN_16K: m = 6'h3E;
         ihd_pkg::WIN_32K: m = 6'h3C;
         ihd_pkg::WIN_64K: m = 6'h38;
         default:          m = 6'h3F;
      endcase
      ok = ((a[18:13] & m) == (shctl1_r[5:0] & m)); // [R10]
      if (!wid) begin
         ok = ok && a[19]; // [R9]
      end else begin
         ok = ok && (a[19] == shctl1_r[ihd_pkg::SH1_A19_BIT]) && (la == shctl2_r[3:0]); // [R11]
      end
      return ok && shctl1_r[ihd_pkg::SH1_EN_BIT]; // [R8]
   endfunction

   // Decode
   logic        wide, io_hit, port_sel, reg_sel, ior_act, iow_act;
   logic        port_rd_end, port_wr_end, reg_wr_end, port_rd_wait, port_wr_wait;
   logic        sh_hit, sh_wait, shm;
   logic [15:0] status_w, step, ram_ofs_mask;
   assign shm      = config_r[ihd_pkg::CFG_SHM_BIT];
   assign wide     = config_r[ihd_pkg::CFG_WTS_BIT] && bus_width_select_pin; // [R21]
   assign step     = wide ? 16'h0002 : 16'h0001; // [R22]
   assign io_hit   = !isa_i.aen && (isa_i.sa[9:5] == ihd_pkg::IO_BASE[9:5]); // [R14]
   assign port_sel = io_hit && !shm && (isa_i.sa[4:1] == ihd_pkg::IO_PORT_OFS[4:1]);
   assign reg_sel  = io_hit && !isa_i.sa[4];
   assign ior_act  = !isa_i.ior_n;
   assign iow_act  = !isa_i.iow_n;
   assign port_rd_end = port_sel && !ior_prev_r && !ior_act;
   assign port_wr_end = port_sel && !iow_prev_r && !iow_act;
   assign reg_wr_end  = reg_sel && !iow_prev_r && !iow_act;
   assign port_rd_wait = port_sel && ior_act && !latch_full_r && !rm_dir_wr_r; // [R2]
   assign port_wr_wait = port_sel && iow_act && latch_full_r; // [R6]
   assign sh_hit  = !isa_i.aen && (!isa_i.mrd_n || !isa_i.mwr_n)
                    && win_match(isa_i.sa, isa_i.la_hi, bus_width_select_pin);
   assign sh_wait = sh_hit && (sh_state_r != ihd_pkg::SH_HOLD); // [R12]
   assign status_w = {11'h000, sh_wait, latch_full_r, rm_dir_wr_r, local_gnt_r,
                      rm_state_r != ihd_pkg::RM_IDLE};
   assign ram_ofs_mask = (shctl2_r[5:4] == ihd_pkg::WIN_8K)  ? 16'h1FFF :
                         (shctl2_r[5:4] == ihd_pkg::WIN_16K) ? 16'h3FFF :
                         (shctl2_r[5:4] == ihd_pkg::WIN_32K) ? 16'h7FFF : 16'hFFFF;

   // APB: zero-wait slave, read data prepared in the setup cycle
   logic apb_wr, apb_mapped;
   assign pready  = 1'b1;
   assign apb_wr  = psel && penable && pwrite;
   assign apb_mapped = (paddr[1:0] == 2'b00) && (paddr <= ihd_pkg::OFS_RADDR);
   assign pslverr = psel && penable && !apb_mapped;

   always_ff @(posedge clk) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata <= apb_mapped ? {16'h0000, reg_word(paddr[4:2], status_w)} : 32'h0000_0000;
      end
   end

   // Write strobes from both sources
   logic       wr_any;
   logic [2:0] wr_idx;
   logic       wr_hi;
   logic [7:0] wr_lo_b;
   logic [7:0] wr_hi_b;
   logic       wr_bytes;
   always_comb begin
      wr_any   = 1'b0;
      wr_idx   = 3'h0;
      wr_hi    = 1'b0;
      wr_lo_b  = 8'h00;
      wr_hi_b  = 8'h00;
      wr_bytes = 1'b0;
      if (apb_wr && apb_mapped) begin
         wr_any   = 1'b1;
         wr_idx   = paddr[4:2];
         wr_lo_b  = pwdata[7:0];
         wr_hi_b  = pwdata[15:8];
         wr_bytes = 1'b1;
      end else if (reg_wr_end) begin
         wr_any  = 1'b1; // [R13]
         wr_idx  = ioofs_r[3:1];
         wr_hi   = ioofs_r[0];
         wr_lo_b = wdat_r[7:0]; // [R17]
         wr_hi_b = wdat_r[7:0];
      end
   end

   function automatic logic [15:0] merge(input logic [15:0] old);
      logic [15:0] v;
      v = old;
      if (wr_bytes) begin
         v = {wr_hi_b, wr_lo_b};
      end else if (wr_hi) begin
         v[15:8] = wr_hi_b;
      end else begin
         v[7:0] = wr_lo_b;
      end
      return v;
   endfunction

   logic cmd_rd, cmd_wr, cmd_abort;
   assign cmd_rd    = wr_any && (wr_idx == 3'h5) && !wr_hi && wr_lo_b[ihd_pkg::CMD_RD_BIT];
   assign cmd_wr    = wr_any && (wr_idx == 3'h5) && !wr_hi && wr_lo_b[ihd_pkg::CMD_WR_BIT];
   assign cmd_abort = wr_any && (wr_idx == 3'h5) && !wr_hi && wr_lo_b[ihd_pkg::CMD_ABORT_BIT];

   // Configuration registers
   always_ff @(posedge clk) begin
      if (rst) begin
         rstart_r <= ihd_pkg::RST_WORD16;
         config_r <= 3'h0;
         shctl1_r <= ihd_pkg::RST_BYTE;
         shctl2_r <= ihd_pkg::RST_BYTE;
      end else if (wr_any) begin
         case (wr_idx)
            3'h0:    rstart_r <= merge(rstart_r);
            3'h2:    config_r <= 3'(merge({13'h0000, config_r}));
            3'h3:    shctl1_r <= 8'(merge({8'h00, shctl1_r}));
            3'h4:    shctl2_r <= 8'(merge({8'h00, shctl2_r}));
            default: rstart_r <= rstart_r;
         endcase
      end
   end

   // Remote address and byte count
   logic advance;
   assign advance = (rm_state_r == ihd_pkg::RM_CAPT)
                    || (rm_state_r == ihd_pkg::RM_ACC && rm_dir_wr_r);
   always_ff @(posedge clk) begin
      if (rst) begin
         raddr_r  <= ihd_pkg::RST_WORD16;
         rcount_r <= ihd_pkg::RST_WORD16;
      end else if (advance) begin
         raddr_r  <= raddr_r + step; // [R1] [R6]
         rcount_r <= (rcount_r > step) ? rcount_r - step : 16'h0000; // [R22]
      end else if (cmd_rd || cmd_wr) begin
         raddr_r  <= rstart_r;
      end else if (wr_any && wr_idx == 3'h1) begin
         rcount_r <= merge(rcount_r);
      end
   end

   // Remote DMA sequencer
   logic ram_free;
   assign ram_free = !local_gnt_r && !local_req && (sh_state_r == ihd_pkg::SH_IDLE) && !sh_hit;
   always_comb begin
      rm_nxt = rm_state_r;
      case (rm_state_r)
         ihd_pkg::RM_IDLE: begin
            if (cmd_rd && rcount_r != 16'h0000) rm_nxt = ihd_pkg::RM_ARB;
            else if (cmd_wr && rcount_r != 16'h0000) rm_nxt = ihd_pkg::RM_HOST;
         end
         ihd_pkg::RM_ARB: begin
            if (ram_free) rm_nxt = ihd_pkg::RM_ACC; // [R5]
         end
         ihd_pkg::RM_ACC: begin
            if (!rm_dir_wr_r) rm_nxt = ihd_pkg::RM_CAPT;
            else if (rcount_r <= step) rm_nxt = ihd_pkg::RM_IDLE; // [R4]
            else rm_nxt = ihd_pkg::RM_HOST;
         end
         ihd_pkg::RM_CAPT: rm_nxt = ihd_pkg::RM_HOST; // [R5]
         ihd_pkg::RM_HOST: begin
            if (rm_dir_wr_r && latch_full_r) begin
               rm_nxt = ihd_pkg::RM_ARB; // [R6]
            end else if (!rm_dir_wr_r && port_rd_end) begin
               rm_nxt = (rcount_r == 16'h0000) ? ihd_pkg::RM_IDLE : ihd_pkg::RM_ARB; // [R3] [R4]
            end
         end
         default: rm_nxt = ihd_pkg::RM_IDLE;
      endcase
      if (cmd_abort) rm_nxt = ihd_pkg::RM_IDLE;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rm_state_r  <= ihd_pkg::RM_IDLE;
         rm_dir_wr_r <= 1'b0;
      end else begin
         rm_state_r <= rm_nxt;
         if (rm_state_r == ihd_pkg::RM_IDLE && (cmd_rd || cmd_wr)) rm_dir_wr_r <= cmd_wr;
      end
   end

   // Port latch
   always_ff @(posedge clk) begin
      if (rst) begin
         latch_r      <= ihd_pkg::RST_WORD16;
         latch_full_r <= 1'b0;
      end else if (rm_state_r == ihd_pkg::RM_CAPT) begin
         latch_r      <= wide ? ram_rdata : {8'h00, raddr_r[0] ? ram_rdata[15:8] : ram_rdata[7:0]}; // [R1]
         latch_full_r <= 1'b1;
      end else if (port_wr_end && rm_state_r == ihd_pkg::RM_HOST && rm_dir_wr_r && !latch_full_r) begin
         latch_r      <= wide ? wdat_r : {8'h00, wdat_r[7:0]}; // [R20] [R17]
         latch_full_r <= 1'b1;
      end else if ((port_rd_end && !rm_dir_wr_r)
                   || (rm_state_r == ihd_pkg::RM_ACC && rm_dir_wr_r) || cmd_abort) begin
         latch_full_r <= 1'b0; // [R3] [R6]
      end
   end

   // Host strobe tracking and write data capture
   always_ff @(posedge clk) begin
      if (rst) begin
         ior_prev_r <= 1'b1;
         iow_prev_r <= 1'b1;
         wdat_r     <= ihd_pkg::RST_WORD16;
         ioofs_r    <= 5'h00;
         wide_acc_r <= 1'b0;
      end else begin
         ior_prev_r <= !((port_sel || reg_sel) && ior_act);
         iow_prev_r <= !((port_sel || reg_sel) && iow_act);
         if (io_hit && (ior_act || iow_act)) begin
            ioofs_r    <= isa_i.sa[4:0];
            wide_acc_r <= wide && port_sel;
         end
         if (io_hit && iow_act) wdat_r <= isa_i.sd;
      end
   end

   // Shared-memory access sequencer
   always_comb begin
      sh_nxt = sh_state_r;
      case (sh_state_r)
         ihd_pkg::SH_IDLE: if (sh_hit && !local_gnt_r) sh_nxt = ihd_pkg::SH_ACC; // [R7]
         ihd_pkg::SH_ACC:  sh_nxt = ihd_pkg::SH_HOLD;
         ihd_pkg::SH_HOLD: if (!sh_hit) sh_nxt = ihd_pkg::SH_IDLE;
         default:          sh_nxt = ihd_pkg::SH_IDLE;
      endcase
   end

   logic        sh_word, sh_cap_r;
   logic [15:0] sh_rd_w;
   assign sh_word = bus_width_select_pin && !isa_i.sbhe_n && !isa_i.sa[0];
   assign sh_rd_w = sh_word ? ram_rdata : {8'h00, isa_i.sa[0] ? ram_rdata[15:8] : ram_rdata[7:0]};
   always_ff @(posedge clk) begin
      if (rst) begin
         sh_state_r <= ihd_pkg::SH_IDLE;
         sh_data_r  <= ihd_pkg::RST_WORD16;
         sh_cap_r   <= 1'b0;
      end else begin
         sh_state_r <= sh_nxt;
         sh_cap_r   <= (sh_state_r == ihd_pkg::SH_ACC);
         if (sh_cap_r) begin
            sh_data_r <= sh_rd_w; // [R12]
         end
      end
   end

   // Local DMA grant: held off by a shared access or remote word already begun
   always_ff @(posedge clk) begin
      if (rst) begin
         local_gnt_r <= 1'b0;
      end else if (local_gnt_r) begin
         local_gnt_r <= local_req;
      end else begin
         local_gnt_r <= local_req && (sh_state_r == ihd_pkg::SH_IDLE) && !sh_hit
                        && (rm_state_r != ihd_pkg::RM_ACC) && (rm_state_r != ihd_pkg::RM_CAPT); // [R7] [R5]
      end
   end
   assign local_gnt = local_gnt_r;

   // RAM request
   always_comb begin
      ram_o = '0;
      if (sh_state_r == ihd_pkg::SH_ACC) begin
         ram_o.en    = 1'b1;
         ram_o.we    = !isa_i.mwr_n;
         ram_o.addr  = isa_i.sa[15:0] & ram_ofs_mask;
         ram_o.be    = sh_word ? 2'h3 : (isa_i.sa[0] ? 2'h2 : 2'h1);
         ram_o.wdata = sh_word ? isa_i.sd : {isa_i.sd[7:0], isa_i.sd[7:0]};
      end else if (rm_state_r == ihd_pkg::RM_ACC) begin
         ram_o.en    = 1'b1; // [R5]
         ram_o.we    = rm_dir_wr_r;
         ram_o.addr  = raddr_r;
         ram_o.be    = wide ? 2'h3 : (raddr_r[0] ? 2'h2 : 2'h1);
         ram_o.wdata = wide ? latch_r : {latch_r[7:0], latch_r[7:0]}; // [R6]
      end
   end

   // ISA read data
   logic [15:0] rd_nxt;
   logic [1:0]  oe_nxt;
   always_comb begin
      rd_nxt = 16'h0000;
      oe_nxt = 2'b11;
      if (port_sel && ior_act && latch_full_r) begin
         rd_nxt = latch_r;
         oe_nxt = wide ? 2'b00 : 2'b10; // [R20] [R16]
      end else if (reg_sel && ior_act) begin
         rd_nxt = isa_i.sa[0] ? {8'h00, 8'(reg_word(isa_i.sa[3:1], status_w) >> 8)}
                              : {8'h00, 8'(reg_word(isa_i.sa[3:1], status_w))};
         oe_nxt = 2'b10; // [R13] [R16]
      end else if (sh_hit && !isa_i.mrd_n && sh_state_r == ihd_pkg::SH_HOLD) begin
         rd_nxt = sh_cap_r ? sh_rd_w : sh_data_r;
         oe_nxt = sh_word ? 2'b00 : 2'b10;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sd_o    <= ihd_pkg::RST_WORD16;
         sd_oe_n <= 2'b11;
      end else begin
         sd_o    <= rd_nxt;
         sd_oe_n <= oe_nxt;
      end
   end

   // CHRDY pulled low while a port wait is needed or a shared access is not yet in SH_HOLD
   assign chrdy_o    = 1'b0;
   assign chrdy_oe_n = !(port_rd_wait || port_wr_wait || sh_wait); // [R15] [R2] [R6] [R7]

   // IO16 for data-port decode in 16-bit mode
   logic late_sel;
   assign late_sel  = config_r[ihd_pkg::CFG_LATE_BIT];
   assign io16_o    = 1'b0;
   assign io16_oe_n = !(port_sel && wide && (!late_sel || ior_act || iow_act)); // [R18]

endmodule

// file: ihd_host_port_assertions.sv
// Port-level property checks for the ISA host data port block
`timescale 1ns/1ns
module ihd_host_port_assertions (
   input wire logic                  clk,
   input wire logic                  rst,
   input wire ihd_pkg::ihd_isa_in_t  isa_i,
   input wire logic                  bus_width_select_pin,
   input wire logic [1:0]            sd_oe_n,
   input wire logic                  chrdy_oe_n,
   input wire logic                  io16_oe_n,
   input wire ihd_pkg::ihd_ram_req_t ram_o,
   input wire logic                  local_req,
   input wire logic                  local_gnt
);
   logic stb;
   logic dec;
   assign stb = !(isa_i.ior_n && isa_i.iow_n && isa_i.mrd_n && isa_i.mwr_n);
   // Data port at 310h
   assign dec = !isa_i.aen && isa_i.sa[9:1] == 9'h188;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   AST_AEN_IGNORED: assert property (isa_i.aen [*3] |-> sd_oe_n == 2'h3 && chrdy_oe_n && io16_oe_n)
      else $error("bus driven during aen cycle");
   AST_LOW_LANE_FIRST: assert property (!sd_oe_n[1] |-> !sd_oe_n[0])
      else $error("high lane driven without low lane");
   AST_WORD_NEEDS_PIN: assert property (sd_oe_n == 2'h0 |-> bus_width_select_pin)
      else $error("word drive with width pin low");
   AST_WAIT_HAS_CAUSE: assert property (!chrdy_oe_n |-> stb || $past(stb) || $past(stb, 2))
      else $error("ready pulled low with no strobe");
   AST_WAIT_ENDS: assert property ($fell(chrdy_oe_n) |-> ##[1:100] chrdy_oe_n)
      else $error("wait never released");
   AST_IO16_DECODE: assert property (!io16_oe_n |-> bus_width_select_pin && (dec || $past(dec)))
      else $error("io16 without port decode");
   AST_LOCAL_EXCLUSIVE: assert property (local_gnt |-> !ram_o.en)
      else $error("ram request during local grant");
   AST_GRANT_ON_REQUEST: assert property ($rose(local_gnt) |-> $past(local_req))
      else $error("grant without local request");
   AST_WORD_RELEASE: assert property (ram_o.en |=> !ram_o.en)
      else $error("ram held past one word");
endmodule

// file: ihd_ram_model.sv
// Buffer RAM and local DMA requester on the far side of the block
`timescale 1ns/1ns
module ihd_ram_model (
   input  wire logic                  clk,
   input  wire ihd_pkg::ihd_ram_req_t ram_i,
   input  wire logic                  ldma_go,
   input  wire logic                  local_gnt,
   output logic [15:0]                rdata,
   output logic                       local_req
);
   logic [15:0] mem [256];
   logic [3:0]  held;
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = {~8'(i), 8'(i)};
      end
      rdata = 16'h0000;
      local_req = 1'h0;
      held = 4'h0;
   end
   // Data one cycle after a read, else a changing pattern
   always @(posedge clk) begin
      rdata <= (ram_i.en && !ram_i.we) ? mem[ram_i.addr[8:1]] : ~rdata;
      if (ram_i.en && ram_i.we && ram_i.be[0]) begin
         mem[ram_i.addr[8:1]][7:0] <= ram_i.wdata[7:0];
      end
      if (ram_i.en && ram_i.we && ram_i.be[1]) begin
         mem[ram_i.addr[8:1]][15:8] <= ram_i.wdata[15:8];
      end
   end
   // Local burst keeps the RAM for sixteen granted cycles
   always @(posedge clk) begin
      if (!local_req) begin
         local_req <= ldma_go;
         held <= 4'h0;
      end else if (local_gnt) begin
         held <= held + 4'h1;
         local_req <= held != 4'hF;
      end
   end
endmodule

// file: testbench.sv
// Self-checking bench for the ISA host data port block
`timescale 1ns/1ns
module testbench;
   logic                  clk, rst, psel, penable, pwrite, pready, pslverr, pin;
   logic [7:0]            paddr;
   logic [31:0]           pwdata, prdata, rd;
   ihd_pkg::ihd_isa_in_t  isa_i;
   logic [15:0]           sd_o, ram_rdata;
   logic [1:0]            sd_oe_n, lanes, w16;
   logic                  chrdy_o, chrdy_oe_n, io16_o, io16_oe_n, local_req, local_gnt;
   ihd_pkg::ihd_ram_req_t ram_o;
   logic                  ldma_go, serr, waited, rdy_s, io_s;
   int                    mismatches, compares, cyc;

   ihd_host_port dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
      .isa_i, .bus_width_select_pin(pin), .sd_o, .sd_oe_n, .chrdy_o, .chrdy_oe_n, .io16_o, .io16_oe_n,
      .ram_o, .ram_rdata, .local_req, .local_gnt);
   ihd_ram_model ram_far (.clk, .ram_i(ram_o), .ldma_go, .local_gnt, .rdata(ram_rdata), .local_req);

   always #25 clk = ~clk;
   // Settled copies for edge-time decisions
   always @(negedge clk) begin
      rdy_s <= chrdy_oe_n;
      io_s <= io16_oe_n;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         end_sim();
      end
   end

   function automatic logic [31:0] mw(input logic [15:0] a);
      return {16'h0000, ~a[8:1], a[8:1]};
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      do @(posedge clk); while (pready !== 1'h1);
      rd = prdata;
      serr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk);
   endtask
   task automatic isa(input logic m, input logic w, input logic [19:0] a, input logic [15:0] d);
      isa_i.sa <= a;
      isa_i.sbhe_n <= a[0];
      isa_i.sd <= d;
      @(posedge clk);
      w16[1] = io_s;
      isa_i.ior_n <= m | w;
      isa_i.iow_n <= m | !w;
      isa_i.mrd_n <= !m | w;
      isa_i.mwr_n <= !m | !w;
      repeat (3) @(posedge clk);
      waited = !rdy_s;
      while (rdy_s !== 1'h1) @(posedge clk);
      repeat (2) @(posedge clk);
      rd = {16'h0000, sd_o};
      lanes = sd_oe_n;
      w16[0] = io_s;
      {isa_i.ior_n, isa_i.iow_n, isa_i.mrd_n, isa_i.mwr_n} <= 4'hF;
      repeat (3) @(posedge clk);
   endtask
   task automatic ldma();
      ldma_go <= 1'h1;
      @(posedge clk);
      ldma_go <= 1'h0;
   endtask
   task automatic end_sim();
      if (mismatches == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   initial begin
      {clk, rst, psel, penable, pwrite, paddr, pwdata, ldma_go, pin} = {2'h1, 3'h0, 8'h00, 32'h0, 2'h1};
      isa_i = {4'h3, 20'h00000, 6'h1F, 16'h0000};
      repeat (20) @(posedge clk);
      rst <= 1'h0;
      repeat (2) @(posedge clk);
      apb(1'h1, ihd_pkg::OFS_CONFIG, 32'h3);
      apb(1'h0, ihd_pkg::OFS_CONFIG, 32'h0);
      chk("config", 32'h3, rd);
      apb(1'h0, 8'h20, 32'h0);
      chk("unmapped", 32'h1, {31'h0, serr});
      isa(1'h0, 1'h0, 20'h00304, 16'h0);
      chk("reg byte", 32'h3, {24'h0, rd[7:0]});
      chk("reg lanes", 32'h2, {30'h0, lanes});
      isa(1'h0, 1'h1, 20'h00306, 16'hA525);
      apb(1'h0, ihd_pkg::OFS_SHCTL1, 32'h0);
      chk("isa reg write", 32'h25, rd);
      isa_i.aen <= 1'h1;
      isa(1'h0, 1'h0, 20'h00304, 16'h0);
      chk("aen lanes", 32'h3, {30'h0, lanes});
      isa_i.aen <= 1'h0;
      apb(1'h1, ihd_pkg::OFS_RSTART, 32'h10);
      apb(1'h1, ihd_pkg::OFS_RCOUNT, 32'h4);
      apb(1'h1, ihd_pkg::OFS_CMD, 32'h1);
      repeat (5) @(posedge clk);
      apb(1'h0, ihd_pkg::OFS_RCOUNT, 32'h0);
      chk("count", 32'h2, rd);
      apb(1'h0, ihd_pkg::OFS_RADDR, 32'h0);
      chk("addr", 32'h12, rd);
      for (int i = 16; i < 20; i += 2) begin
         isa(1'h0, 1'h0, 20'h00310, 16'h0);
         chk("port word", mw(16'(i)), rd);
         chk("io16 late", 32'h2, {30'h0, w16});
      end
      apb(1'h0, ihd_pkg::OFS_STATUS, 32'h0);
      chk("busy", 32'h0, {31'h0, rd[0]});
      apb(1'h1, ihd_pkg::OFS_CONFIG, 32'h0);
      apb(1'h1, ihd_pkg::OFS_RSTART, 32'h21);
      apb(1'h1, ihd_pkg::OFS_RCOUNT, 32'h1);
      ldma();
      apb(1'h1, ihd_pkg::OFS_CMD, 32'h1);
      isa(1'h0, 1'h0, 20'h00310, 16'h0);
      chk("stall", 32'h1, {31'h0, waited});
      chk("port byte", 32'hEF, {24'h0, rd[7:0]});
      chk("byte lanes", 32'h2, {30'h0, lanes});
      apb(1'h1, ihd_pkg::OFS_RCOUNT, 32'h1);
      apb(1'h1, ihd_pkg::OFS_CMD, 32'h2);
      apb(1'h0, ihd_pkg::OFS_STATUS, 32'h0);
      chk("wr busy", 32'h5, rd);
      apb(1'h1, ihd_pkg::OFS_CMD, 32'h4);
      apb(1'h0, ihd_pkg::OFS_STATUS, 32'h0);
      chk("abort", 32'h4, rd);
      apb(1'h1, ihd_pkg::OFS_CONFIG, 32'h1);
      apb(1'h1, ihd_pkg::OFS_RSTART, 32'h40);
      apb(1'h1, ihd_pkg::OFS_RCOUNT, 32'h4);
      apb(1'h1, ihd_pkg::OFS_CMD, 32'h2);
      isa(1'h0, 1'h1, 20'h00310, 16'h5AA5);
      isa(1'h0, 1'h1, 20'h00310, 16'hC33C);
      repeat (10) @(posedge clk);
      chk("ram w0", 32'h5AA5, {16'h0, ram_far.mem[8'h20]});
      chk("ram w1", 32'hC33C, {16'h0, ram_far.mem[8'h21]});
      apb(1'h0, ihd_pkg::OFS_RCOUNT, 32'h0);
      chk("wr count", 32'h0, rd);
      pin <= 1'h0;
      apb(1'h1, ihd_pkg::OFS_CONFIG, 32'h4);
      apb(1'h1, ihd_pkg::OFS_SHCTL1, 32'hC6);
      for (int s = 0; s < 4; s++) begin
         apb(1'h1, ihd_pkg::OFS_SHCTL2, 32'(16 * s + 3));
         isa(1'h1, 1'h0, 20'h8C022 ^ (20'h01000 << s), 16'h0);
         chk("hit", 32'h11, {24'h0, rd[7:0]});
         isa(1'h1, 1'h0, 20'h8C022 ^ (20'h02000 << s), 16'h0);
         chk("miss", 32'h3, {30'h0, lanes});
      end
      isa(1'h1, 1'h0, 20'h0C022, 16'h0);
      chk("a19 low", 32'h3, {30'h0, lanes});
      apb(1'h1, ihd_pkg::OFS_SHCTL1, 32'h86);
      isa(1'h1, 1'h0, 20'h8C022, 16'h0);
      chk("disabled", 32'h3, {30'h0, lanes});
      pin <= 1'h1;
      apb(1'h1, ihd_pkg::OFS_SHCTL1, 32'h46);
      apb(1'h1, ihd_pkg::OFS_SHCTL2, 32'h3);
      ldma();
      isa(1'h1, 1'h0, 20'h0C022, 16'h0);
      chk("shared wait", 32'h1, {31'h0, waited});
      chk("shared word", mw(16'h0022), rd);
      isa(1'h1, 1'h1, 20'h0C024, 16'h1234);
      chk("shared write", 32'h1234, {16'h0, ram_far.mem[8'h12]});
      end_sim();
   end
endmodule

bind ihd_host_port ihd_host_port_assertions chk_i (.clk, .rst, .isa_i, .bus_width_select_pin, .sd_oe_n,
   .chrdy_oe_n, .io16_oe_n, .ram_o, .local_req, .local_gnt);
